// *** verilog/pport_pkg.sv ***
// Package for the parallel port control, mode and address block.
// Assumes a single 250 MHz instruction clock and a plain register port.
package pport_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_MODE    = 4'h1;
    localparam logic [3:0] OFS_TARGET  = 4'h2;
    localparam logic [3:0] OFS_DATA    = 4'h3;
    localparam logic [3:0] OFS_FLAGS   = 4'h4;
    // Control register field positions
    localparam int CTL_ON     = 15;
    localparam int CTL_HALT   = 13;
    localparam int CTL_MUX    = 11;
    localparam int CTL_BE_ON  = 10;
    localparam int CTL_WR_ON  = 9;
    localparam int CTL_RD_ON  = 8;
    localparam int CTL_CSF    = 6;
    localparam int CTL_ALP    = 5;
    localparam int CTL_SELECT_TWO_POLARITY   = 4;
    localparam int CTL_SELECT_ONE_POLARITY   = 3;
    localparam int CTL_BEP    = 2;
    localparam int CTL_WRITE_STROBE_POLARITY   = 1;
    localparam int CTL_READ_STROBE_POLARITY   = 0;
    // Mode register field positions
    localparam int MOD_BUSY   = 15;
    localparam int MOD_IRQ    = 13;
    localparam int MOD_STEP   = 11;
    localparam int MOD_WIDE   = 10;
    localparam int MOD_PORT   = 8;
    localparam int MOD_SETUP  = 6;
    localparam int MOD_STROBE = 2;
    localparam int MOD_HOLD   = 0;
    // Flags register field positions
    localparam int FLG_OVF    = 1;
    localparam int FLG_UNF    = 0;
    // Reset values
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    localparam logic [15:0] RST_MODE    = 16'h0000;
    localparam logic [15:0] RST_TARGET  = 16'h0000;
    // Writable bits of control and mode
    localparam logic [15:0] MASK_CONTROL = 16'hbfff;
    localparam logic [15:0] MASK_MODE    = 16'h7fff;
    // Encodings
    localparam logic [1:0] PORT_LEGACY = 2'h0;
    localparam logic [1:0] PORT_ADDR   = 2'h1;
    localparam logic [1:0] PORT_MAST2  = 2'h2;
    localparam logic [1:0] PORT_MAST1  = 2'h3;
    localparam logic [1:0] MUX_NONE    = 2'h0;
    localparam logic [1:0] MUX_PART    = 2'h1;
    localparam logic [1:0] MUX_FULL    = 2'h2;
    localparam logic [1:0] CSF_ADDR    = 2'h0;
    localparam logic [1:0] CSF_ONE     = 2'h1;
    localparam logic [1:0] CSF_BOTH    = 2'h2;
    localparam logic [1:0] IRQ_EACH    = 2'h1;
    localparam logic [1:0] IRQ_STALL   = 2'h2;
    localparam logic [1:0] IRQ_BUF3    = 2'h3;
    localparam logic [1:0] STEP_INC    = 2'h1;
    localparam logic [1:0] STEP_DEC    = 2'h2;
    localparam logic [1:0] STEP_BUF    = 2'h3;
    // Gap between consecutive bus cycles, in instruction cycles
    localparam int GAP_CYCLES = 1;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR_LO, ST_ADDR_HI, ST_SETUP, ST_STROBE, ST_HOLD, ST_GAP
    } bus_state_t;
endpackage

// *** verilog/pport_cfg_if.sv ***
// Interface carrying decoded configuration to the wait-state counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pport_cfg_if;
    logic       load;
    logic [3:0] count;
    logic       done;
    modport ctrl (output load, output count, input done);
    modport tmr  (input load, input count, output done);
endinterface
`default_nettype wire

// *** verilog/pport_wait_timer.sv ***
// Down-counter that times one phase of a bus cycle.
// Assumes load is a one-cycle pulse; done is high while the count is zero.
`timescale 1ns/1ps
`default_nettype none
module pport_wait_timer (
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    pport_cfg_if.tmr  cfg
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    // Reload on request, else count down to zero
    always_comb begin
        cnt_d = cnt_q;
        if (cfg.load) begin
            cnt_d = cfg.count;
        end else if (cnt_q != 4'h0) begin
            cnt_d = cnt_q - 4'h1;
        end
    end
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
    // Done looks at the count alone; gating it with load would close a loop through the sequencer
    assign cfg.done = (cnt_q == 4'h0);
endmodule
`default_nettype wire

// *** verilog/pport_master.sv ***
// Control, mode and address logic of an 8-bit parallel port.
// Assumes synchronous pins, a plain register port and an idle input from the core.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Port enable clear means no off-chip access at all.
// - Halt-when-idle bit stops port activity while the core is idle.
// - Mux field places address on data pins fully, partly, or not at all.
// - Separate enables connect byte-enable, write/enable and read strobe pins.
// - Chip-select field makes lines selects or address bits 15 and 14.
// - Latch and select polarity bits: set high, clear low; ignored as address.
// - Byte-enable polarity bit: set means active high.
// - Write polarity bit sets enable strobe polarity in master mode 1.
// - Read polarity bit sets read/write strobe polarity in master mode 1.
// - Busy flag reads one while a master transfer runs.
// - Interrupt field: none, per cycle, or stall during transfer.
// - Mode 11 interrupts on buffer 3 or slave address 11 access.
// - Step field increments or decrements address bits 10:0 per cycle.
// - Step mode 11 auto-increments slave buffers in legacy slave mode only.
// - Wide mode makes two byte transfers per data access.
// - Port mode field picks master 1, master 2, addressable or legacy slave.
// - Setup wait and address phase last one to four cycles.
// - Strobe wait adds zero to fifteen cycles.
// - Hold wait lasts one to four cycles.
// - Strobe wait zero ignores setup and hold, single-cycle strobe.
// - One idle cycle between consecutive bus operations.
// - Top two address bits drive chip selects two and one.
// - Address bits 13:0 go to address pins or multiplexed data.
// - Host write to full input byte sets sticky overflow flag.
// - Host read of empty output byte sets sticky underflow flag.
module pport_master
    import pport_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        core_idle_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    output logic             stall_out,
    output logic             irq_out,
    input  wire logic        slave_access_in,
    input  wire logic        slave_write_in,
    input  wire logic [1:0]  slave_sel_in,
    input  wire logic        slave_full_in,
    input  wire logic        slave_empty_in,
    output logic             buf_step_out,
    input  wire logic [7:0]  port_data_pins_in,
    output logic      [7:0]  port_data_pins_out,
    output logic             port_data_pins_oe_out,
    output logic      [13:0] port_location_pins_out,
    output logic             chip_select_one_pin_out,
    output logic             chip_select_two_pin_out,
    output logic             read_strobe_pin_out,
    output logic             write_strobe_pin_out,
    output logic             byte_enable_pin_out,
    output logic             low_latch_strobe_out,
    output logic             high_latch_strobe_out
);
    logic [15:0] ctl_q, ctl_d, mode_q, mode_d, tgt_q, tgt_d, data_q, data_d;
    logic        ovf_q, ovf_d, unf_q, unf_d, wr_q, wr_d, hi_q, hi_d, irq_q, irq_d;
    logic        rd_pend_q, rd_pend_d;
    logic [15:0] rdata_q, rdata_d;
    bus_state_t  st_q, st_d;
    pport_cfg_if cfg ();

    pport_wait_timer u_timer (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .cfg        (cfg)
    );

    // Decoded fields
    logic       port_on, halted, is_master, wide, strobe_zero;
    logic [1:0] mux, chip_select_function, interrupt_mode_select, step, pmode;
    logic [3:0] setup_n, strobe_n, hold_n;
    logic       start;
    assign port_on     = ctl_q[CTL_ON];
    assign halted      = ctl_q[CTL_HALT] && core_idle_in;
    assign mux         = ctl_q[CTL_MUX +: 2];
    assign chip_select_function         = ctl_q[CTL_CSF +: 2];
    assign interrupt_mode_select        = mode_q[MOD_IRQ +: 2];
    assign step        = mode_q[MOD_STEP +: 2];
    assign wide        = mode_q[MOD_WIDE];
    assign pmode       = mode_q[MOD_PORT +: 2];
    assign is_master   = pmode[1];
    assign setup_n     = {2'h0, mode_q[MOD_SETUP +: 2]};
    assign strobe_n    = mode_q[MOD_STROBE +: 4];
    assign hold_n      = {2'h0, mode_q[MOD_HOLD +: 2]};
    assign strobe_zero = (strobe_n == 4'h0);
    // Data register access launches a bus cycle only when enabled and master
    assign start = port_on && !halted && is_master && (st_q == ST_IDLE)
                   && (reg_addr_in == OFS_DATA) && (reg_wr_in || reg_rd_in);

    // Bus cycle sequencer; the timer holds a phase for n extra cycles
    always_comb begin
        st_d      = st_q;
        cfg.load  = 1'b0;
        cfg.count = 4'h0;
        unique case (st_q)
            ST_IDLE: begin
                if (start) begin
                    if (mux == MUX_FULL) begin
                        st_d = ST_ADDR_HI;
                    end else if (mux == MUX_PART) begin
                        st_d = ST_ADDR_LO;
                    end else begin
                        st_d = strobe_zero ? ST_STROBE : ST_SETUP;
                    end
                    cfg.load  = 1'b1;
                    cfg.count = strobe_zero ? 4'h0 : setup_n;
                end
            end
            ST_ADDR_HI: begin
                if (cfg.done) begin
                    st_d      = ST_ADDR_LO;
                    cfg.load  = 1'b1;
                    cfg.count = strobe_zero ? 4'h0 : setup_n;
                end
            end
            ST_ADDR_LO: begin
                if (cfg.done) begin
                    st_d      = strobe_zero ? ST_STROBE : ST_SETUP;
                    cfg.load  = 1'b1;
                    cfg.count = strobe_zero ? 4'h0 : setup_n;
                end
            end
            ST_SETUP: begin
                if (cfg.done) begin
                    st_d      = ST_STROBE;
                    cfg.load  = 1'b1;
                    cfg.count = strobe_n;
                end
            end
            ST_STROBE: begin
                if (cfg.done) begin
                    st_d      = strobe_zero ? ST_GAP : ST_HOLD;
                    cfg.load  = 1'b1;
                    cfg.count = hold_n;
                end
            end
            ST_HOLD: begin
                if (cfg.done) begin
                    st_d = ST_GAP;
                end
            end
            ST_GAP: begin
                // Second byte of a wide access reruns the cycle after the gap, skipping the high address phase
                if (wide && !hi_q) begin
                    st_d      = (mux == MUX_NONE) ? (strobe_zero ? ST_STROBE : ST_SETUP)
                                                  : ST_ADDR_LO;
                    cfg.load  = 1'b1;
                    cfg.count = strobe_zero ? 4'h0 : setup_n;
                end else begin
                    st_d = ST_IDLE;
                end
            end
        endcase
        if (!port_on) begin
            st_d = ST_IDLE;
        end
    end

    // Register file, address stepping and sticky slave flags
    logic cycle_end;
    assign cycle_end = (st_q == ST_GAP);
    always_comb begin
        ctl_d     = ctl_q;
        mode_d    = mode_q;
        tgt_d     = tgt_q;
        data_d    = data_q;
        ovf_d     = ovf_q;
        unf_d     = unf_q;
        wr_d      = wr_q;
        hi_d      = hi_q;
        rd_pend_d = 1'b0;
        irq_d     = 1'b0;
        rdata_d   = 16'h0000;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_CONTROL: ctl_d  = reg_wdata_in & MASK_CONTROL;
                OFS_MODE:    mode_d = reg_wdata_in & MASK_MODE;
                OFS_TARGET:  tgt_d  = reg_wdata_in;
                OFS_DATA:    data_d = reg_wdata_in;
                OFS_FLAGS: begin
                    ovf_d = ovf_q & ~reg_wdata_in[FLG_OVF];
                    unf_d = unf_q & ~reg_wdata_in[FLG_UNF];
                end
                default: ;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_CONTROL: rdata_d = ctl_q;
                OFS_MODE:    rdata_d = {st_q != ST_IDLE, mode_q[14:0]};
                OFS_TARGET:  rdata_d = tgt_q;
                OFS_DATA:    rdata_d = wide ? data_q : {8'h00, data_q[7:0]};
                OFS_FLAGS:   rdata_d = {14'h0000, ovf_q, unf_q};
                default:     rdata_d = 16'h0000;
            endcase
        end
        if (start) begin
            wr_d = reg_wr_in;
            hi_d = 1'b0;
        end
        // Capture read data at strobe end, low byte first
        if (st_q == ST_STROBE && cfg.done && !wr_q) begin
            if (hi_q) begin
                data_d[15:8] = port_data_pins_in;
            end else begin
                data_d[7:0] = port_data_pins_in;
            end
        end
        if (cycle_end) begin
            hi_d = 1'b1;
            if (step == STEP_INC) begin
                tgt_d[10:0] = tgt_q[10:0] + 11'h001;
            end else if (step == STEP_DEC) begin
                tgt_d[10:0] = tgt_q[10:0] - 11'h001;
            end
            irq_d = (interrupt_mode_select == IRQ_EACH);
        end
        // Slave side events: set wins over a software clear
        if (port_on && !halted && !is_master && slave_access_in) begin
            if (slave_write_in && slave_full_in) begin
                ovf_d = 1'b1;
            end
            if (!slave_write_in && slave_empty_in) begin
                unf_d = 1'b1;
            end
            if (interrupt_mode_select == IRQ_BUF3 && slave_sel_in == 2'h3) begin
                irq_d = 1'b1;
            end
        end
    end
    assign buf_step_out = port_on && !halted && (pmode == PORT_LEGACY)
                          && (step == STEP_BUF) && slave_access_in;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_q     <= RST_CONTROL;
            mode_q    <= RST_MODE;
            tgt_q     <= RST_TARGET;
            data_q    <= 16'h0000;
            ovf_q     <= 1'b0;
            unf_q     <= 1'b0;
            wr_q      <= 1'b0;
            hi_q      <= 1'b0;
            irq_q     <= 1'b0;
            rd_pend_q <= 1'b0;
            rdata_q   <= 16'h0000;
            st_q      <= ST_IDLE;
        end else begin
            ctl_q     <= ctl_d;
            mode_q    <= mode_d;
            tgt_q     <= tgt_d;
            data_q    <= data_d;
            ovf_q     <= ovf_d;
            unf_q     <= unf_d;
            wr_q      <= wr_d;
            hi_q      <= hi_d;
            irq_q     <= irq_d;
            rd_pend_q <= rd_pend_d;
            rdata_q   <= rdata_d;
            st_q      <= st_d;
        end
    end
    assign reg_rdata_out = rdata_q;
    assign irq_out       = irq_q;
    // Stall covers the transfer except its gap cycles, the trailing one and the one between wide bytes
    assign stall_out = (interrupt_mode_select == IRQ_STALL) && (st_q != ST_IDLE) && (st_q != ST_GAP);

    // Pin drive; polarity bits only matter where a pin is a strobe, select or byte enable
    logic strobe_act, sel_act, act;
    assign act        = port_on && (st_q != ST_IDLE) && (st_q != ST_GAP);
    assign strobe_act = (st_q == ST_STROBE);
    assign sel_act    = act;
    always_comb begin
        logic rd_a, wr_a;
        rd_a = 1'b0;
        wr_a = 1'b0;
        if (pmode == PORT_MAST1) begin
            rd_a = sel_act && !wr_q;    // Read/write level, high means read
            wr_a = strobe_act;          // Enable strobe
        end else begin
            rd_a = strobe_act && !wr_q;
            wr_a = strobe_act && wr_q;
        end
        read_strobe_pin_out  = ctl_q[CTL_RD_ON] & (rd_a ~^ ctl_q[CTL_READ_STROBE_POLARITY]);
        write_strobe_pin_out = ctl_q[CTL_WR_ON] & (wr_a ~^ ctl_q[CTL_WRITE_STROBE_POLARITY]);
        if (!ctl_q[CTL_RD_ON]) read_strobe_pin_out = 1'b0;
        byte_enable_pin_out = ctl_q[CTL_BE_ON] && wide
                              && ((act && hi_q) ~^ ctl_q[CTL_BEP]);
        low_latch_strobe_out  = (st_q == ST_ADDR_LO) ~^ ctl_q[CTL_ALP];
        high_latch_strobe_out = (st_q == ST_ADDR_HI) ~^ ctl_q[CTL_ALP];
        chip_select_two_pin_out = (chip_select_function == CSF_ADDR) ? tgt_q[15]
                                : ((sel_act && tgt_q[15]) ~^ ctl_q[CTL_SELECT_TWO_POLARITY]);
        chip_select_one_pin_out = (chip_select_function == CSF_BOTH)
                                ? ((sel_act && tgt_q[14]) ~^ ctl_q[CTL_SELECT_ONE_POLARITY])
                                : tgt_q[14];
        port_location_pins_out = tgt_q[13:0];
        port_data_pins_oe_out  = act && (wr_q || st_q == ST_ADDR_LO || st_q == ST_ADDR_HI);
        if (st_q == ST_ADDR_HI) begin
            port_data_pins_out = tgt_q[15:8];
        end else if (st_q == ST_ADDR_LO) begin
            port_data_pins_out = tgt_q[7:0];
        end else begin
            port_data_pins_out = hi_q ? data_q[15:8] : data_q[7:0];
        end
    end

    // Checks
    sequence s_start;
        start && !strobe_zero;
    endsequence
    AST_BUSY_READ: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        reg_rd_in && reg_addr_in == OFS_MODE && st_q != ST_IDLE |=> reg_rdata_out[15])
        else $error("busy flag missing during transfer");
    AST_OFF_QUIET: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !port_on |=> st_q == ST_IDLE)
        else $error("bus cycle while port disabled");
    AST_GAP: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        st_q == ST_HOLD && st_d == ST_GAP |=> !strobe_act)
        else $error("no gap after cycle");
    AST_OVF: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        port_on && !halted && !is_master && slave_access_in && slave_write_in
        && slave_full_in |=> ovf_q)
        else $error("overflow not flagged");
    AST_UNF: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        port_on && !halted && !is_master && slave_access_in && !slave_write_in
        && slave_empty_in |=> unf_q)
        else $error("underflow not flagged");
    AST_ZERO_STROBE: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        st_q == ST_STROBE && strobe_zero |=> st_q == ST_GAP)
        else $error("zero wait strobe longer than one cycle");
    AST_SETUP: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_start ##0 (mux == MUX_NONE && setup_n == 4'h0) |=> st_q == ST_SETUP ##1 st_q == ST_STROBE)
        else $error("setup phase length wrong");
    AST_STALL: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        interrupt_mode_select == IRQ_STALL && st_q == ST_STROBE |-> stall_out)
        else $error("no stall during transfer");
endmodule
`default_nettype wire

// *** verification/pport_peer.sv ***
// Behavioural external peripheral on the far side of the parallel pins.
// Assumes an active-high read strobe; drives data only while it is read.
`timescale 1ns/1ps
`default_nettype none
module pport_peer #(
    parameter logic [7:0] RD_DATA = 8'h5a
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       rd_strobe_in,
    input  wire logic       host_oe_in,
    output logic      [7:0] data_out
);
    logic [7:0] junk_q;
    // Released bus shows a changing pattern, never a stale value
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            junk_q <= 8'h3c;
        end else begin
            junk_q <= ~junk_q + 8'h01;
        end
    end
    assign data_out = (rd_strobe_in && !host_oe_in) ? RD_DATA : junk_q;
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the parallel port control and address block.
// Assumes the register offsets and field positions of the design package.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pport_pkg::*;
    logic ref_clk_in, rst_b_in, core_idle_in, reg_wr_in, reg_rd_in;
    logic [3:0] reg_addr_in;
    logic [15:0] reg_wdata_in, reg_rdata_out, v;
    logic stall_out, irq_out, buf_step_out, oe, cs1, cs2, rdp, wrp, byte_enable_polarity, lls, hls;
    logic sa, sw, sf, se;
    logic [1:0] ssel;
    logic [7:0] din, dout;
    logic [13:0] loc;
    int bad_count, samples_checked, wr_hi, wr_lo, wr_rise, rd_hi, irq_n, stall_n;
    int be_n, hl_n, ll_n;
    logic [15:0] loc_seen, cs1_seen, dat_seen;
    pport_master dut_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .core_idle_in(core_idle_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .stall_out(stall_out), .irq_out(irq_out), .slave_access_in(sa), .slave_write_in(sw),
        .slave_sel_in(ssel), .slave_full_in(sf), .slave_empty_in(se),
        .buf_step_out(buf_step_out), .port_data_pins_in(din), .port_data_pins_out(dout),
        .port_data_pins_oe_out(oe), .port_location_pins_out(loc),
        .chip_select_one_pin_out(cs1), .chip_select_two_pin_out(cs2),
        .read_strobe_pin_out(rdp), .write_strobe_pin_out(wrp), .byte_enable_pin_out(byte_enable_polarity),
        .low_latch_strobe_out(lls), .high_latch_strobe_out(hls));
    pport_peer peer_u (.clk_in(ref_clk_in), .rst_b_in(rst_b_in), .rd_strobe_in(rdp),
        .host_oe_in(oe),
        .data_out(din));
    // Clock generator, 4 ns period, starting low
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a; reg_wdata_in <= d; reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a; reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    // Pins sampled mid-cycle, away from the launching edge
    // Select, address and data are captured only while the write strobe is at its active level
    task automatic watch(input int n, input logic lvl);
        logic pw;
        wr_hi = 0; wr_lo = 0; wr_rise = 0; rd_hi = 0; irq_n = 0; stall_n = 0; pw = wrp;
        be_n = 0; hl_n = 0; ll_n = 0;
        loc_seen = 16'hffff; cs1_seen = 16'hffff; dat_seen = 16'hffff;
        repeat (n) @(negedge ref_clk_in) begin
            if (wrp === lvl) begin
                loc_seen = {2'h0, loc}; cs1_seen = {15'h0, cs1}; dat_seen = {7'h00, oe, dout};
            end
            if (wrp === 1'b1) wr_hi++;
            if (wrp === 1'b0) wr_lo++;
            if (byte_enable_polarity === 1'b1) be_n++;
            if (hls === 1'b1) hl_n++;
            if (lls === 1'b1) ll_n++;
            if (wrp === 1'b1 && pw === 1'b0) wr_rise++;
            if (rdp === 1'b1) rd_hi++;
            if (irq_out === 1'b1) irq_n++;
            if (stall_out === 1'b1) stall_n++;
            pw = wrp;
        end
    endtask
    // Configure, then start one data access while watching the pins
    task automatic bus(input logic [15:0] ctl, mode, tgt, input logic is_rd);
        wr(OFS_CONTROL, ctl); wr(OFS_MODE, mode); wr(OFS_TARGET, tgt);
        fork
            begin
                @(posedge ref_clk_in);
                reg_addr_in <= OFS_DATA; reg_wdata_in <= 16'h00a5;
                if (is_rd) reg_rd_in <= 1'b1; else reg_wr_in <= 1'b1;
                @(posedge ref_clk_in);
                reg_rd_in <= 1'b0; reg_wr_in <= 1'b0;
            end
            watch(60, ctl[CTL_WRITE_STROBE_POLARITY]);
        join
    endtask
    task automatic slave_hit(input logic w, f, e, q);
        @(posedge ref_clk_in);
        sa <= 1'b1; sw <= w; sf <= f; se <= e;
        @(negedge ref_clk_in);
        chk({15'h0, buf_step_out}, 16'h0001);
        @(posedge ref_clk_in);
        sa <= 1'b0;
        @(negedge ref_clk_in);
        chk({15'h0, irq_out}, {15'h0, q});
    endtask
    task automatic t_regs();
        rd(OFS_CONTROL, v); chk(v, 16'h0000);
        rd(OFS_MODE, v); chk(v, 16'h0000);
        rd(OFS_TARGET, v); chk(v, 16'h0000);
        rd(4'h5, v); chk(v, 16'h0000);
        wr(OFS_MODE, 16'hffff); rd(OFS_MODE, v); chk(v, 16'h7fff);
        wr(OFS_MODE, 16'h0000);
    endtask
    task automatic t_master();
        bus(16'h838b, 16'h2a0c, 16'h4010, 1'b0);
        chk(16'(wr_hi), 16'h0004);
        chk(16'(rd_hi), 16'h0000);
        chk(16'(irq_n), 16'h0001);
        chk(loc_seen, 16'h0010);
        chk(cs1_seen, 16'h0001);
        chk(dat_seen, 16'h01a5);
        rd(OFS_TARGET, v); chk(v, 16'h4011);
        rd(OFS_MODE, v); chk(v, 16'h2a0c);
        bus(16'h878f, 16'h0604, 16'h0000, 1'b0);
        chk(16'(wr_rise), 16'h0002);
        chk(16'(be_n), 16'h0004);
        chk(16'(irq_n), 16'h0000);
        bus(16'h838b, 16'h52c3, 16'h8000, 1'b1);
        chk(16'(rd_hi), 16'h0001);
        chk(16'(wr_hi), 16'h0000);
        chk(16'(stall_n), 16'h0001);
        rd(OFS_TARGET, v); chk(v, 16'h87ff);
        rd(OFS_DATA, v); chk(v, 16'h005a);
        bus(16'h8380, 16'h0304, 16'h4000, 1'b0);
        chk(16'(wr_lo), 16'h0002);
        chk(cs1_seen, 16'h0000);
        // Fully multiplexed: two-cycle address phases ahead of the strobe
        bus(16'h9323, 16'h0244, 16'h1234, 1'b0);
        chk(16'(hl_n), 16'h0002);
        chk(16'(ll_n), 16'h0002);
        chk(16'(wr_hi), 16'h0002);
    endtask
    task automatic t_off();
        bus(16'h038b, 16'h020c, 16'h0000, 1'b0);
        chk(16'(wr_hi), 16'h0000);
        @(posedge ref_clk_in);
        core_idle_in <= 1'b1;
        bus(16'ha38b, 16'h020c, 16'h0000, 1'b0);
        chk(16'(wr_hi), 16'h0000);
        @(posedge ref_clk_in);
        core_idle_in <= 1'b0;
    endtask
    task automatic t_slave();
        wr(OFS_CONTROL, 16'h8000); wr(OFS_MODE, 16'h1800);
        slave_hit(1'b1, 1'b1, 1'b0, 1'b0);
        rd(OFS_FLAGS, v); chk(v, 16'h0002);
        wr(OFS_FLAGS, 16'h0002); rd(OFS_FLAGS, v); chk(v, 16'h0000);
        slave_hit(1'b0, 1'b0, 1'b1, 1'b0);
        rd(OFS_FLAGS, v); chk(v, 16'h0001);
        wr(OFS_MODE, 16'h7800);
        slave_hit(1'b0, 1'b0, 1'b0, 1'b1);
        @(posedge ref_clk_in);
        ssel <= 2'h2;
        slave_hit(1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the run needs
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        bad_count = 0; samples_checked = 0;
        rst_b_in = 1'b0; core_idle_in = 1'b0; reg_wr_in = 1'b0; reg_rd_in = 1'b0;
        reg_addr_in = 4'h0; reg_wdata_in = 16'h0000;
        sa = 1'b0; sw = 1'b0; sf = 1'b0; se = 1'b0; ssel = 2'h3;
        repeat (20) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_master();
        t_off();
        t_slave();
        tally_and_finish();
    end
endmodule
`default_nettype wire
